/* File: src/dcc_cfg.svh */
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// channel and trigger line counts
`define DCC_NUM_CHAN 32
`define DCC_NUM_TRIG 85

// register indices (byte address is four times the index)
`define DCC_IDX_CTRL 8'h00
`define DCC_IDX_DESC_BASE 8'h34
`define DCC_IDX_WB_BASE 8'h38
`define DCC_IDX_CHAN_SEL 8'h3F
`define DCC_IDX_CTRL_A 8'h40
`define DCC_IDX_CMD 8'h44
`define DCC_IDX_PRIO 8'h45

// byte addresses on the bus
`define DCC_ADDR_CTRL ({2'b00, `DCC_IDX_CTRL, 2'b00})
`define DCC_ADDR_DESC_BASE ({2'b00, `DCC_IDX_DESC_BASE, 2'b00})
`define DCC_ADDR_WB_BASE ({2'b00, `DCC_IDX_WB_BASE, 2'b00})
`define DCC_ADDR_CHAN_SEL ({2'b00, `DCC_IDX_CHAN_SEL, 2'b00})
`define DCC_ADDR_CTRL_A ({2'b00, `DCC_IDX_CTRL_A, 2'b00})
`define DCC_ADDR_CMD ({2'b00, `DCC_IDX_CMD, 2'b00})
`define DCC_ADDR_PRIO ({2'b00, `DCC_IDX_PRIO, 2'b00})

// field positions
`define DCC_CTRL_EN_BIT 1
`define DCC_THR_MSB 29
`define DCC_THR_LSB 28
`define DCC_BURST_MSB 27
`define DCC_BURST_LSB 24
`define DCC_TACT_MSB 21
`define DCC_TACT_LSB 20
`define DCC_TSRC_MSB 15
`define DCC_TSRC_LSB 8
`define DCC_RSTBY_BIT 6
`define DCC_EN_BIT 1
`define DCC_CHANNEL_SOFT_RESET_BIT 0

// encodings and reset values
`define DCC_TACT_RESERVED 2'h1
`define DCC_CMD_SUSPEND 2'h1
`define DCC_CMD_RESUME 2'h2
`define DCC_CMD_RESERVED 2'h3
`define DCC_TSRC_NONE 8'h00
`define DCC_RST_WORD 32'h00000000

`endif

/* File: src/dcc_pkg.sv */
`default_nettype none
package dcc_pkg;

    // per-channel software settings
    typedef struct packed {
        logic [1:0] threshold;
        logic [3:0] beats_per_burst;
        logic [1:0] trigger_action_sel;
        logic [7:0] trigger_source_sel;
        logic run_in_standby;
        logic [1:0] priority_level_sel;
        logic [1:0] command;
    } dcc_chan_cfg_t;

    // per-channel view handed to the transfer engine and arbiter
    typedef struct packed {
        logic [3:0] threshold_beats;
        logic [4:0] burst_beats;
        logic [1:0] trigger_action_sel;
        logic [1:0] priority_level_sel;
        logic run;
        logic abort;
    } dcc_chan_out_t;

    typedef enum logic [3:0] {
        DCC_CH_OFF = 4'b0001,
        DCC_CH_ON = 4'b0010,
        DCC_CH_ABORT = 4'b0100,
        DCC_CH_RST = 4'b1000
    } dcc_ch_state_t;

endpackage
`default_nettype wire

/* File: src/dcc_top.sv */
`include "dcc_cfg.svh"
`default_nettype none
module dcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire logic [`DCC_NUM_TRIG-1:0] periph_req,
    input wire logic [`DCC_NUM_CHAN-1:0] chan_busy,
    output dcc_pkg::dcc_chan_out_t [`DCC_NUM_CHAN-1:0] channel_out,
    output logic [`DCC_NUM_CHAN-1:0] channel_trigger,
    output logic [`DCC_NUM_CHAN-1:0] suspend_cmd,
    output logic [`DCC_NUM_CHAN-1:0] resume_cmd,
    output logic [31:0] descriptor_base,
    output logic [31:0] writeback_base,
    output logic controller_enable
);
    import dcc_pkg::*;

    dcc_chan_cfg_t cfg_q [`DCC_NUM_CHAN];
    dcc_ch_state_t state_q [`DCC_NUM_CHAN];

    logic [4:0] channel_select_id;
    logic [`DCC_NUM_TRIG-1:0] req_meta;
    logic [`DCC_NUM_TRIG-1:0] req_sync;

    logic [31:0] wmask;

    logic addr_hit;

    logic wr_en;
    logic setup_rd;

    logic wr_ctrl;
    logic wr_desc;
    logic wr_wb;
    logic wr_sel;
    logic wr_ctrl_a;
    logic wr_cmd;
    logic wr_prio;

    logic [31:0] next_ctrl_word;
    logic [31:0] next_desc;
    logic [31:0] next_wb;
    logic [31:0] next_ctrl_a;
    logic [31:0] next_cmd;
    logic [31:0] next_prio;
    logic [31:0] next_sel;

    logic [31:0] rd_word;
    logic [31:0] ctrl_a_view;
    dcc_chan_cfg_t sel_cfg;
    dcc_ch_state_t sel_state;

    // byte enables widened to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // address decode; misaligned or unknown words are refused
    always_comb begin
        addr_hit = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            case (paddr)
                `DCC_ADDR_CTRL, `DCC_ADDR_DESC_BASE, `DCC_ADDR_WB_BASE,
                `DCC_ADDR_CHAN_SEL, `DCC_ADDR_CTRL_A, `DCC_ADDR_CMD,
                `DCC_ADDR_PRIO: addr_hit = 1'b1;
                default: addr_hit = 1'b0;
            endcase
        end
    end

    // zero wait states: the access phase always completes at once
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_en = psel & penable & pwrite & addr_hit;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_ctrl = wr_en & (paddr == `DCC_ADDR_CTRL);
    assign wr_desc = wr_en & (paddr == `DCC_ADDR_DESC_BASE);
    assign wr_wb = wr_en & (paddr == `DCC_ADDR_WB_BASE);
    assign wr_sel = wr_en & (paddr == `DCC_ADDR_CHAN_SEL);
    assign wr_ctrl_a = wr_en & (paddr == `DCC_ADDR_CTRL_A);
    assign wr_cmd = wr_en & (paddr == `DCC_ADDR_CMD);
    assign wr_prio = wr_en & (paddr == `DCC_ADDR_PRIO);

    // selected channel view for reads and byte merging
    assign sel_cfg = cfg_q[channel_select_id];
    assign sel_state = state_q[channel_select_id];

    // channel control word as software sees it
    always_comb begin
        ctrl_a_view = `DCC_RST_WORD;
        ctrl_a_view[`DCC_THR_MSB:`DCC_THR_LSB] = sel_cfg.threshold;
        ctrl_a_view[`DCC_BURST_MSB:`DCC_BURST_LSB] = sel_cfg.beats_per_burst;
        ctrl_a_view[`DCC_TACT_MSB:`DCC_TACT_LSB] = sel_cfg.trigger_action_sel;
        ctrl_a_view[`DCC_TSRC_MSB:`DCC_TSRC_LSB] = sel_cfg.trigger_source_sel;
        ctrl_a_view[`DCC_RSTBY_BIT] = sel_cfg.run_in_standby;
        // enable stays high through a graceful abort
        ctrl_a_view[`DCC_EN_BIT] = (sel_state == DCC_CH_ON) ||
                                   (sel_state == DCC_CH_ABORT);
        ctrl_a_view[`DCC_CHANNEL_SOFT_RESET_BIT] = (sel_state == DCC_CH_RST);
    end

    // merged write values: untouched byte lanes keep their old contents
    assign next_ctrl_word = ({31'h0, controller_enable} << `DCC_CTRL_EN_BIT) & ~wmask |
                            pwdata & wmask;
    assign next_desc = descriptor_base & ~wmask | pwdata & wmask;
    assign next_wb = writeback_base & ~wmask | pwdata & wmask;
    assign next_ctrl_a = ctrl_a_view & ~wmask | pwdata & wmask;
    assign next_cmd = {30'h0, sel_cfg.command} & ~wmask | pwdata & wmask;
    assign next_prio = {30'h0, sel_cfg.priority_level_sel} & ~wmask | pwdata & wmask;
    assign next_sel = {27'h0, channel_select_id} & ~wmask | pwdata & wmask;

    // read mux
    always_comb begin
        case (paddr)
            `DCC_ADDR_CTRL: rd_word = {30'h0, controller_enable, 1'b0};
            `DCC_ADDR_DESC_BASE: rd_word = descriptor_base;
            `DCC_ADDR_WB_BASE: rd_word = writeback_base;
            `DCC_ADDR_CHAN_SEL: rd_word = {27'h0, channel_select_id};
            `DCC_ADDR_CTRL_A: rd_word = ctrl_a_view;
            `DCC_ADDR_CMD: rd_word = {30'h0, sel_cfg.command};
            `DCC_ADDR_PRIO: rd_word = {30'h0, sel_cfg.priority_level_sel};
            default: rd_word = `DCC_RST_WORD;
        endcase
    end

    // read data captured in the setup phase so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `DCC_RST_WORD;
        end else if (clk_en && setup_rd) begin
            prdata <= (addr_hit && paddr[1:0] == 2'b00) ? rd_word : `DCC_RST_WORD;
        end
    end

    // global controller enable and channel selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_enable <= 1'b0;
            channel_select_id <= 5'h00;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                controller_enable <= next_ctrl_word[`DCC_CTRL_EN_BIT];
            end
            if (wr_sel) begin
                channel_select_id <= next_sel[4:0];
            end
        end
    end

    // base addresses only move while the controller is stopped;
    // low address bits are passed on as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            descriptor_base <= `DCC_RST_WORD;
            writeback_base <= `DCC_RST_WORD;
        end else if (clk_en && !controller_enable) begin
            if (wr_desc) begin
                descriptor_base <= next_desc;
            end
            if (wr_wb) begin
                writeback_base <= next_wb;
            end
        end
    end

    // request lines come from other logic islands, two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_meta <= '0;
            req_sync <= '0;
        end else if (clk_en) begin
            req_meta <= periph_req;
            req_sync <= req_meta;
        end
    end

    // one slice per channel
    genvar ch;
    generate
        for (ch = 0; ch < `DCC_NUM_CHAN; ch++) begin : g_chan
            logic hit;
            logic en_wr;
            logic rst_wr;
            logic locked;
            logic run;
            logic src_valid;

            dcc_chan_cfg_t c;

            assign hit = (channel_select_id == 5'(ch));
            assign en_wr = wr_ctrl_a && hit && pstrb[0];
            assign rst_wr = en_wr && next_ctrl_a[`DCC_CHANNEL_SOFT_RESET_BIT];
            assign locked = controller_enable || (state_q[ch] != DCC_CH_OFF);
            assign c = cfg_q[ch];

            // halted while in standby unless told to keep going
            assign run = (state_q[ch] == DCC_CH_ON || state_q[ch] == DCC_CH_ABORT) &&
                         (!standby || c.run_in_standby);
            assign src_valid = (c.trigger_source_sel != `DCC_TSRC_NONE) &&
                               (c.trigger_source_sel < 8'(`DCC_NUM_TRIG));

            // enable, graceful abort and soft reset sequencing
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    state_q[ch] <= DCC_CH_OFF;
                end else if (clk_en) begin
                    case (state_q[ch])
                        DCC_CH_OFF: begin
                            // reset wins over a same-write enable
                            if (rst_wr) begin
                                state_q[ch] <= DCC_CH_RST;
                            end else if (en_wr && next_ctrl_a[`DCC_EN_BIT]) begin
                                state_q[ch] <= DCC_CH_ON;
                            end
                        end
                        DCC_CH_ON: begin
                            // a reset write here is ignored
                            if (en_wr && !next_ctrl_a[`DCC_EN_BIT]) begin
                                state_q[ch] <= chan_busy[ch] ? DCC_CH_ABORT :
                                               DCC_CH_OFF;
                            end
                        end
                        DCC_CH_ABORT: begin
                            // enabling again cancels the abort
                            if (en_wr && next_ctrl_a[`DCC_EN_BIT]) begin
                                state_q[ch] <= DCC_CH_ON;
                            end else if (!chan_busy[ch]) begin
                                state_q[ch] <= DCC_CH_OFF;
                            end
                        end
                        DCC_CH_RST: begin
                            // settings clear on this same edge
                            state_q[ch] <= DCC_CH_OFF;
                        end
                        default: begin
                            state_q[ch] <= DCC_CH_OFF;
                        end
                    endcase
                end
            end

            // channel settings; most stay writable while running
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[ch] <= '0;
                end else if (clk_en) begin
                    if (state_q[ch] == DCC_CH_RST) begin
                        cfg_q[ch] <= '0;
                    end else begin
                        if (wr_ctrl_a && hit) begin
                            cfg_q[ch].threshold <=
                                next_ctrl_a[`DCC_THR_MSB:`DCC_THR_LSB];
                            cfg_q[ch].beats_per_burst <=
                                next_ctrl_a[`DCC_BURST_MSB:`DCC_BURST_LSB];
                            cfg_q[ch].run_in_standby <=
                                next_ctrl_a[`DCC_RSTBY_BIT];
                            // the reserved action code is not accepted
                            if (next_ctrl_a[`DCC_TACT_MSB:`DCC_TACT_LSB] !=
                                `DCC_TACT_RESERVED) begin
                                cfg_q[ch].trigger_action_sel <=
                                    next_ctrl_a[`DCC_TACT_MSB:`DCC_TACT_LSB];
                            end
                            if (!locked) begin
                                cfg_q[ch].trigger_source_sel <=
                                    next_ctrl_a[`DCC_TSRC_MSB:`DCC_TSRC_LSB];
                            end
                        end
                        if (wr_cmd && hit && next_cmd[1:0] != `DCC_CMD_RESERVED) begin
                            cfg_q[ch].command <= next_cmd[1:0];
                        end
                        if (wr_prio && hit) begin
                            cfg_q[ch].priority_level_sel <= next_prio[1:0];
                        end
                    end
                end
            end

            // command strobes, one cycle per accepted write
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    suspend_cmd[ch] <= 1'b0;
                    resume_cmd[ch] <= 1'b0;
                end else if (clk_en) begin
                    suspend_cmd[ch] <= wr_cmd && hit &&
                                       next_cmd[1:0] == `DCC_CMD_SUSPEND;
                    resume_cmd[ch] <= wr_cmd && hit &&
                                      next_cmd[1:0] == `DCC_CMD_RESUME;
                end
            end

            // registered view for the engine; trigger taken from selected line
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_out[ch] <= '0;
                    channel_trigger[ch] <= 1'b0;
                end else if (clk_en) begin
                    // single-beat bursts ignore the threshold
                    channel_out[ch].threshold_beats <= (c.beats_per_burst == 4'h0) ? 4'h1 :
                        4'(4'h1 << c.threshold);
                    channel_out[ch].burst_beats <= {1'b0, c.beats_per_burst} + 5'h01;
                    channel_out[ch].trigger_action_sel <= c.trigger_action_sel;
                    channel_out[ch].priority_level_sel <= c.priority_level_sel;
                    channel_out[ch].run <= run && controller_enable;
                    channel_out[ch].abort <= (state_q[ch] == DCC_CH_ABORT);
                    channel_trigger[ch] <= run && controller_enable && src_valid &&
                        req_sync[c.trigger_source_sel[6:0]];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* File: tb/dcc_sva.sv */
`include "dcc_cfg.svh"
`default_nettype none
module dcc_sva
    import dcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic standby,
    input wire logic [`DCC_NUM_TRIG-1:0] periph_req,
    input wire logic [`DCC_NUM_CHAN-1:0] chan_busy,
    input wire dcc_chan_out_t [`DCC_NUM_CHAN-1:0] channel_out,
    input wire logic [`DCC_NUM_CHAN-1:0] channel_trigger,
    input wire logic [`DCC_NUM_CHAN-1:0] suspend_cmd,
    input wire logic [`DCC_NUM_CHAN-1:0] resume_cmd,
    input wire logic [31:0] descriptor_base,
    input wire logic [31:0] writeback_base,
    input wire logic controller_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_go;
    // a write lands only in an access cycle with the clock enabled
    assign wr_go = psel && penable && pwrite && clk_en;
    ready_always_a: assert property (pready) else $error("wait state inserted");
    misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    mapped_ok_a: assert property (psel && penable && paddr == `DCC_ADDR_CTRL_A |-> !pslverr)
        else $error("mapped access refused");
    base_lock_a: assert property (controller_enable && wr_go &&
        paddr == `DCC_ADDR_DESC_BASE |=> $stable(descriptor_base))
        else $error("locked base changed");
    base_load_a: assert property (!controller_enable && wr_go && pstrb == 4'hF &&
        paddr == `DCC_ADDR_WB_BASE |=> writeback_base == $past(pwdata))
        else $error("base write lost");
    suspend_cause_a: assert property (|suspend_cmd |->
        $past(wr_go && paddr == `DCC_ADDR_CMD) && $past(pwdata[1:0]) == 2'h1)
        else $error("stray suspend");
    resume_cause_a: assert property (|resume_cmd |->
        $past(wr_go && paddr == `DCC_ADDR_CMD) && $past(pwdata[1:0]) == 2'h2)
        else $error("stray resume");
    trig_gate_a: assert property (|channel_trigger |-> $past(controller_enable))
        else $error("trigger while controller off");
    // every channel is watched, the bench only configures one of them
    for (genvar i = 0; i < `DCC_NUM_CHAN; i++) begin : g_ch
        thr_single_a: assert property ($past(presetn) &&
            channel_out[i].burst_beats == 5'h1 |-> channel_out[i].threshold_beats == 4'h1)
            else $error("single beat thr");
        beat_range_a: assert property ($past(presetn) |->
            $onehot(channel_out[i].threshold_beats) && channel_out[i].burst_beats != 5'h0)
            else $error("beat count range");
    end
    cover property (|suspend_cmd);
    cover property (|resume_cmd);
    cover property (|channel_trigger);
    cover property (psel && penable && pslverr);
endmodule
bind dcc_top dcc_sva dcc_sva_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
    .periph_req(periph_req), .chan_busy(chan_busy), .channel_out(channel_out),
    .channel_trigger(channel_trigger), .suspend_cmd(suspend_cmd), .resume_cmd(resume_cmd),
    .descriptor_base(descriptor_base), .writeback_base(writeback_base),
    .controller_enable(controller_enable));
`default_nettype wire

/* File: tb/dcc_trig_model.sv */
`include "dcc_cfg.svh"
`default_nettype none
module dcc_trig_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] src_idx,
    input wire logic fire,
    input wire logic [4:0] busy_ch,
    input wire logic busy_on,
    output logic [`DCC_NUM_TRIG-1:0] periph_req,
    output logic [`DCC_NUM_CHAN-1:0] chan_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // unselected lines chatter at random, so a wrong source mux shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_req <= '0;
        end else begin
            periph_req <= 85'({$urandom(), $urandom(), $urandom()}) & ~(85'h1 << src_idx) |
                          (85'(fire) << src_idx);
        end
    end
    // engine holds busy for as long as the bench keeps a burst open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_busy <= '0;
        end else begin
            chan_busy <= 32'(busy_on) << busy_ch;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_dcc_top.sv */
`include "dcc_cfg.svh"
`default_nettype none
module tb_dcc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, standby = 1'b0, fire = 1'b0, busy_on = 1'b0;
    logic pready, pslverr, controller_enable;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, descriptor_base, writeback_base, base;
    logic [3:0] pstrb = 4'hF, b;
    logic [7:0] src = 8'h00;
    logic [4:0] ch = 5'h00;
    logic [1:0] act, prev;
    logic [`DCC_NUM_TRIG-1:0] periph_req;
    logic [31:0] chan_busy, channel_trigger, suspend_cmd, resume_cmd;
    dcc_chan_out_t [`DCC_NUM_CHAN-1:0] channel_out;
    logic [32:0] expq[$];
    int error_cnt = 0, checks_done = 0, cycles = 0, n, m;
    always #12.5 pclk = ~pclk;
    dcc_top dcc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
        .periph_req(periph_req), .chan_busy(chan_busy), .channel_out(channel_out),
        .channel_trigger(channel_trigger), .suspend_cmd(suspend_cmd),
        .resume_cmd(resume_cmd), .descriptor_base(descriptor_base),
        .writeback_base(writeback_base), .controller_enable(controller_enable));
    dcc_trig_model dcc_trig_model_inst (.pclk(pclk), .presetn(presetn), .src_idx(src),
        .fire(fire), .busy_ch(ch), .busy_on(busy_on), .periph_req(periph_req),
        .chan_busy(chan_busy));
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; waits for pready, the timeout bounds the wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        expq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    function automatic logic [31:0] mk_a(input logic [1:0] t, input logic [3:0] bl,
        input logic [1:0] ac, input logic [7:0] s, input logic sb, input logic en);
        mk_a = {2'h0, t, bl, 2'h0, ac, 4'h0, s, 1'h0, sb, 4'h0, en, 1'h0};
    endfunction
    // read data with its error flag against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, expq.pop_front(), "rd");
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            results();
        end
    end
    initial begin
        n = $urandom(32'h69D8);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`DCC_ADDR_DESC_BASE, 33'h0);
        rd(`DCC_ADDR_CTRL_A, 33'h0);
        rd(`DCC_ADDR_PRIO, 33'h0);
        rd(12'h008, {1'b1, 32'h0});
        rd(12'h0D1, {1'b1, 32'h0});
        base = $urandom() & 32'hFFFFFFF0;
        apb(1'b1, `DCC_ADDR_DESC_BASE, base);
        apb(1'b1, `DCC_ADDR_WB_BASE, ~base & 32'hFFFFFFF0);
        rd(`DCC_ADDR_DESC_BASE, {1'b0, base});
        chk(33'(writeback_base), 33'(~base & 32'hFFFFFFF0), "wb base");
        ch = 5'($urandom_range(1, 31));
        apb(1'b1, `DCC_ADDR_CHAN_SEL, 32'(ch));
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h3, 4'h0, 2'h0, 8'h00, 1'b0, 1'b0));
        settle(2);
        chk(33'(channel_out[ch].threshold_beats), 33'h1, "thr single");
        for (int t = 0; t < 4; t++) begin
            b = (t == 3) ? 4'hF : 4'($urandom_range(1, 14));
            apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'(t), b, 2'h0, 8'h00, 1'b0, 1'b0));
            settle(2);
            chk(33'(channel_out[ch].threshold_beats), 33'(1 << t), "thr");
            chk(33'(channel_out[ch].burst_beats), 33'(b) + 33'h1, "burst");
        end
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h3, 4'hF, 2'h0, 8'h00, 1'b0, 1'b0)});
        prev = 2'h0;
        for (int i = 0; i < 4; i++) begin
            act = 2'(32'h0312 >> (4 * i));
            if (act != 2'h1) prev = act;
            apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, act, 8'h00, 1'b0, 1'b0));
            settle(2);
            chk(33'(channel_out[ch].trigger_action_sel), 33'(prev), "action");
        end
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, `DCC_ADDR_PRIO, 32'(p));
            rd(`DCC_ADDR_PRIO, 33'(p));
            settle(1);
            chk(33'(channel_out[ch].priority_level_sel), 33'(p), "prio");
        end
        apb(1'b1, `DCC_ADDR_CHAN_SEL, 32'(ch ^ 5'h1));
        rd(`DCC_ADDR_PRIO, 33'h0);
        apb(1'b1, `DCC_ADDR_CHAN_SEL, 32'(ch));
        // suspend, resume, then the reserved code which must change nothing
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, `DCC_ADDR_CMD, 32'(c));
            n = 0;
            m = 0;
            repeat (4) begin
                #1;
                n += int'(suspend_cmd === (32'h1 << ch));
                m += int'(resume_cmd === (32'h1 << ch));
                @(posedge pclk);
            end
            chk(33'(n), 33'(c == 1), "suspend pulse");
            chk(33'(m), 33'(c == 2), "resume pulse");
        end
        rd(`DCC_ADDR_CMD, 33'h2);
        src = 8'($urandom_range(1, 84));
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src, 1'b0, 1'b0));
        apb(1'b1, `DCC_ADDR_CTRL, 32'h2);
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src, 1'b0, 1'b1));
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h0, 4'h0, 2'h0, src, 1'b0, 1'b1)});
        @(posedge pclk);
        fire <= 1'b1;
        settle(6);
        chk(33'(channel_trigger), 33'(32'h1 << ch), "trigger");
        @(posedge pclk);
        fire <= 1'b0;
        settle(6);
        chk(33'(channel_trigger), 33'h0, "trigger off");
        apb(1'b1, `DCC_ADDR_DESC_BASE, 32'h0);
        rd(`DCC_ADDR_DESC_BASE, {1'b0, base});
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src ^ 8'h1, 1'b0, 1'b1));
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h0, 4'h0, 2'h0, src, 1'b0, 1'b1)});
        @(posedge pclk);
        standby <= 1'b1;
        settle(3);
        chk(33'(channel_out[ch].run), 33'h0, "standby halt");
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b1));
        settle(3);
        chk(33'(channel_out[ch].run), 33'h1, "standby run");
        @(posedge pclk);
        standby <= 1'b0;
        busy_on <= 1'b1;
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b0));
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b1)});
        settle(1);
        chk(33'(channel_out[ch].abort), 33'h1, "abort");
        apb(1'b1, `DCC_ADDR_CTRL_A, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b0) | 32'h1);
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b1)});
        busy_on <= 1'b0;
        settle(4);
        rd(`DCC_ADDR_CTRL_A, {1'b0, mk_a(2'h0, 4'h0, 2'h0, src, 1'b1, 1'b0)});
        apb(1'b1, `DCC_ADDR_CTRL_A, 32'h1);
        rd(`DCC_ADDR_CTRL_A, 33'h0);
        rd(`DCC_ADDR_PRIO, 33'h0);
        rd(`DCC_ADDR_CMD, 33'h0);
        clk_en <= 1'b0;
        apb(1'b1, `DCC_ADDR_PRIO, 32'h3);
        clk_en <= 1'b1;
        rd(`DCC_ADDR_PRIO, 33'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`DCC_ADDR_DESC_BASE, 33'h0);
        chk(33'(controller_enable), 33'h0, "ctrl after reset");
        @(posedge pclk);
        results();
    end
endmodule
`default_nettype wire
